// ==== rioc_defines.vh ====
// Shared constants for the relay scheme logic
`ifndef RIOC_DEFINES_VH
`define RIOC_DEFINES_VH

// ------
// Timing
// ------
`define RIOC_CLK_HZ 250000000
`define RIOC_TICK_MS 10
`define RIOC_TICK_CYC ((`RIOC_CLK_HZ / 1000) * `RIOC_TICK_MS)
`define RIOC_CTF_DROP_MS 100
`define RIOC_CTF_DROP_TICKS (`RIOC_CTF_DROP_MS / `RIOC_TICK_MS)
`define RIOC_CTF_ERR_S 10
`define RIOC_CTF_ERR_TICKS (`RIOC_CTF_ERR_S * 1000 / `RIOC_TICK_MS)
`define RIOC_HOLD_MAX_TICKS 10'd1000
`define RIOC_BI_MAX_TICKS 15'd30000

// ------
// Register offsets
// ------
`define RIOC_REG_POLARITY 8'h00
`define RIOC_REG_GROUPSEL 8'h04
`define RIOC_REG_CTF_CTRL 8'h08
`define RIOC_REG_STATUS 8'h0C
`define RIOC_REG_ALARM_MAP 8'h10
`define RIOC_REG_FUNC_BASE 8'h20
`define RIOC_REG_BI_PU_BASE 8'h40
`define RIOC_REG_BI_DO_BASE 8'h60
`define RIOC_REG_OUT_BASE 8'h80

// ------
// Output reset modes and CT fail enable settings
// ------
`define RIOC_MODE_INST 2'h0
`define RIOC_MODE_DELAY 2'h1
`define RIOC_MODE_DWELL 2'h2
`define RIOC_MODE_LATCH 2'h3
`define RIOC_CT_FAIL_ENABLE_SWITCH_OFF 2'h0
`define RIOC_CT_FAIL_ENABLE_SWITCH_ON 2'h1
`define RIOC_CT_FAIL_ENABLE_SWITCH_OPT 2'h2

// Input function bit positions
`define RIOC_F_RCL_BLK 0
`define RIOC_F_RCL_RDY 1
`define RIOC_F_RCL_INI 2
`define RIOC_F_RCL_NA 3
`define RIOC_F_MAN_CLS 4
`define RIOC_F_FRQ_BLK 5
`define RIOC_F_CTF_BLK 6
`define RIOC_F_CTF_EXT 7
`define RIOC_F_VTF_BLK 8
`define RIOC_F_VTF_EXT 9
`define RIOC_F_TC_FAIL 10
`define RIOC_F_CB_NO 11
`define RIOC_F_CB_NC 12
`define RIOC_F_TRIP_3P 13
`define RIOC_F_TRIP_A 14
`define RIOC_F_TRIP_B 15
`define RIOC_F_TRIP_C 16
`define RIOC_F_RMT_RST 17
`define RIOC_F_SYNC 18
`define RIOC_F_REC 19
`define RIOC_NFUNC 20

`endif

// ==== rioc_bin_input.v ====
// One binary input: synchroniser, polarity and pick-up/drop-off delays
`timescale 1ns/1ns
`include "rioc_defines.vh"

module rioc_bin_input #(
  parameter TW = 15
) (
  input wire core_clk, // Clock
  input wire rst, // Sync reset, active high
  input wire ce, // Clock enable
  input wire tick, // 10 ms tick
  input wire pin, // Raw field input
  input wire invert, // Polarity select
  input wire [TW-1:0] pu_ticks, // Pick-up delay in ticks
  input wire [TW-1:0] do_ticks, // Drop-off delay in ticks
  output reg out_q // Conditioned level
);

  reg s1_q;
  reg s2_q;
  reg [TW-1:0] cnt_q;
  wire lvl;

  // --------------------------------------------------------------
  // Synchroniser; field contacts are asynchronous
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  assign lvl = s2_q ^ invert;

  // --------------------------------------------------------------
  // Delay: counter runs while level differs from output
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      out_q <= 1'b0;
      cnt_q <= {TW{1'b0}};
    end else if (ce) begin
      if (lvl == out_q) begin
        cnt_q <= {TW{1'b0}};
      end else if (cnt_q >= (lvl ? pu_ticks : do_ticks)) begin
        out_q <= lvl;
        cnt_q <= {TW{1'b0}};
      end else if (tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

// ==== rioc_out_relay.v ====
// One configurable output relay: 4-input AND/OR gate and reset mode
`timescale 1ns/1ns
`include "rioc_defines.vh"

module rioc_out_relay #(
  parameter NSIG = 32,
  parameter SW = 5,
  parameter HW = 10
) (
  input wire core_clk, // Clock
  input wire rst, // Sync reset, active high
  input wire ce, // Clock enable
  input wire tick, // 10 ms tick
  input wire [NSIG-1:0] sig, // Internal signal list
  input wire [4*SW-1:0] sel, // Four signal selectors
  input wire [3:0] gate_en, // Gate inputs in use
  input wire use_and, // 1 = AND, 0 = OR
  input wire [1:0] mode, // Reset characteristic
  input wire [HW-1:0] hold_ticks, // Hold time in ticks
  input wire latch_clr, // Release latched output
  output reg out_q // Relay drive
);

  reg [HW-1:0] cnt_q;
  reg gate;
  integer i;

  // --------------------------------------------------------------
  // Gate; unused inputs are neutral for either function
  // --------------------------------------------------------------
  always @* begin
    gate = use_and ? (gate_en != 4'h0) : 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (gate_en[i]) begin
        if (use_and) begin
          gate = gate & sig[sel[i*SW +: SW]];
        end else begin
          gate = gate | sig[sel[i*SW +: SW]];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Reset characteristic; zero hold behaves as instantaneous
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      out_q <= 1'b0;
      cnt_q <= {HW{1'b0}};
    end else if (ce) begin
      case (mode)
        `RIOC_MODE_INST: begin
          out_q <= gate;
          cnt_q <= {HW{1'b0}};
        end
        `RIOC_MODE_DELAY: begin
          if (gate) begin
            out_q <= 1'b1;
            cnt_q <= {HW{1'b0}};
          end else if (out_q && cnt_q >= hold_ticks) begin
            out_q <= 1'b0;
          end else if (out_q && tick) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        `RIOC_MODE_DWELL: begin
          if (!out_q) begin
            out_q <= gate;
            cnt_q <= {HW{1'b0}};
          end else if (cnt_q < hold_ticks) begin
            if (tick) begin
              cnt_q <= cnt_q + 1'b1;
            end
          end else begin
            out_q <= gate;
          end
        end
        default: begin
          if (latch_clr) begin
            out_q <= gate;
          end else if (gate) begin
            out_q <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// ==== rioc_top.v ====
// Relay scheme logic: input mapping, output relays, CT fail supervision
// Function
// - Inputs map to reclose and frequency-block functions
// - Inputs block CT_FAIL_SIGNAL/VTF supervision; external fail inputs
// - Four external trip inputs initiate breaker failure
// - Remote reset clears trip indication and latches
// - Clock-sync and record-store input functions
// - Each input selects off or group 1-4
// - Four alarms shown when mapped input raised
// - Any signal routes to seven configurable relays
// - Each output gates four signals, AND or OR
// - Reset modes: instant, delayed, dwell, latched
// - Dwell holds short pulses, follows long ones
// - Hold time 0.00-10.00 s in 10 ms
// - Relay-fail output on defect or supply fault
// - CT supervision only in three-phase configuration
// - CT fail: residual current without residual voltage
// - CT fail alarms and blocks dependent protection
// - CT fail drops 100 ms after clearing in auto-reset mode
// - CT fail lasting 10 s posts error
// - External CT fail input declares failure
// - Enable switch: off, latching, or auto-reset
// - Input polarity, pick-up, drop-off 0-300 s
`timescale 1ns/1ns
`include "rioc_defines.vh"

module rioc_top #(
  parameter NBI = 8,
  parameter NBO = 7,
  parameter TICK_CYC = `RIOC_TICK_CYC,
  parameter CTF_ERR_TICKS = `RIOC_CTF_ERR_TICKS
) (
  input wire core_clk, // Clock, 250 MHz
  input wire rst, // Sync reset, active high
  input wire ce, // Clock enable, freezes state when low
  input wire [7:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata_q, // Read data, cycle after strobe
  input wire [NBI-1:0] bin_pin, // Raw binary inputs
  input wire [7:0] prot_sig, // Internal protection signals
  input wire residual_overcurrent_detect, // Residual current element
  input wire residual_overvoltage_detect, // Residual voltage element
  input wire relay_defect, // Self-check defect
  input wire dc_supply_fault, // Internal supply abnormal
  input wire trip_cmd, // Protection trip command
  output reg [NBO-1:0] output_relay, // Configurable relay drives
  output reg relay_fail_out_q, // Relay failure contact
  output reg trip_ind_q, // Trip indication
  output reg [2:0] active_group_q, // Active group 0..3 (groups 1..4)
  output reg [3:0] alarm_show_q, // Alarm text display requests
  output reg ct_fail_signal_q, // CT failure signal
  output reg ct_fail_err_q, // CT fail error message
  output reg ct_fail_block_q, // Block dependent protection
  output reg ct_fail_alarm_q, // CT fail alarm
  output reg [`RIOC_NFUNC-1:0] func_q, // Mapped input functions
  output reg breaker_fail_init_q, // Breaker failure initiate
  output reg record_store_q, // Store disturbance record, pulse
  output reg clock_sync_q // Clock sync, pulse
);

  localparam SW = 5;
  localparam BTW = 15;
  localparam HW = 10;

  // --------------------------------------------------------------
  // Settings registers
  // --------------------------------------------------------------
  reg [NBI-1:0] polarity_q;
  reg [3*NBI-1:0] group_sel_q;
  reg [1:0] ctf_en_q;
  reg three_phase_q;
  reg [4*NBI-1:0] alarm_map_q;
  reg [`RIOC_NFUNC*NBI-1:0] func_map_q;
  reg [BTW*NBI-1:0] bi_pu_q;
  reg [BTW*NBI-1:0] bi_do_q;
  reg [32*NBO-1:0] out_cfg_q;
  reg [HW*NBO-1:0] out_hold_q;
  reg [31:0] tick_cnt_q;
  reg tick;
  reg [3:0] drop_cnt_q;
  reg [13:0] err_cnt_q;
  reg [NBI-1:0] bi_prev_q;
  reg [2:0] grp_d;
  integer k;
  integer j;

  wire [NBI-1:0] bi;
  wire [31:0] sig;
  wire [NBO-1:0] relay_w;
  wire ctf_detect;
  wire [`RIOC_NFUNC-1:0] func_d;

  // Saturate a register word into a tick count
  function [BTW-1:0] clip_bi;
    input [31:0] v;
    begin
      clip_bi = (v > `RIOC_BI_MAX_TICKS) ? `RIOC_BI_MAX_TICKS : v[BTW-1:0];
    end
  endfunction

  function [HW-1:0] clip_hold;
    input [31:0] v;
    begin
      clip_hold = (v > `RIOC_HOLD_MAX_TICKS) ? `RIOC_HOLD_MAX_TICKS : v[HW-1:0];
    end
  endfunction

  // --------------------------------------------------------------
  // Common 10 ms tick
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      tick_cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= (tick_cnt_q == TICK_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == TICK_CYC - 1) ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // --------------------------------------------------------------
  // Binary inputs
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NBI; g = g + 1) begin : g_bi
      rioc_bin_input #(
        .TW(BTW)
      ) u_bi (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .pin(bin_pin[g]),
        .invert(polarity_q[g]),
        .pu_ticks(bi_pu_q[g*BTW +: BTW]),
        .do_ticks(bi_do_q[g*BTW +: BTW]),
        .out_q(bi[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------
  // Function mapping: OR of assigned inputs
  // --------------------------------------------------------------
  generate
    for (g = 0; g < `RIOC_NFUNC; g = g + 1) begin : g_fn
      wire [NBI-1:0] hits;
      genvar m;
      for (m = 0; m < NBI; m = m + 1) begin : g_m
        assign hits[m] = bi[m] & func_map_q[m*`RIOC_NFUNC + g];
      end
      assign func_d[g] = |hits;
    end
  endgenerate

  // Function outputs and edge pulses
  always @(posedge core_clk) begin
    if (rst) begin
      func_q <= {`RIOC_NFUNC{1'b0}};
      breaker_fail_init_q <= 1'b0;
      record_store_q <= 1'b0;
      clock_sync_q <= 1'b0;
      bi_prev_q <= {NBI{1'b0}};
    end else if (ce) begin
      func_q <= func_d;
      breaker_fail_init_q <= func_d[`RIOC_F_TRIP_3P] | func_d[`RIOC_F_TRIP_A] |
                             func_d[`RIOC_F_TRIP_B] | func_d[`RIOC_F_TRIP_C];
      record_store_q <= func_d[`RIOC_F_REC] & ~func_q[`RIOC_F_REC];
      clock_sync_q <= func_d[`RIOC_F_SYNC] & ~func_q[`RIOC_F_SYNC];
      bi_prev_q <= bi;
    end
  end

  // --------------------------------------------------------------
  // Group select, alarms, trip indication, relay fail
  // --------------------------------------------------------------
  always @* begin
    grp_d = active_group_q;
    for (k = 0; k < NBI; k = k + 1) begin
      if (bi[k] && group_sel_q[3*k +: 3] != 3'h0 && group_sel_q[3*k +: 3] <= 3'h4) begin
        grp_d = group_sel_q[3*k +: 3] - 3'h1;
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      active_group_q <= 3'h0;
      alarm_show_q <= 4'h0;
      trip_ind_q <= 1'b0;
      relay_fail_out_q <= 1'b0;
    end else if (ce) begin
      active_group_q <= grp_d;
      for (j = 0; j < 4; j = j + 1) begin
        alarm_show_q[j] <= |(bi & alarm_map_q[j*NBI +: NBI]);
      end
      if (trip_cmd) begin
        trip_ind_q <= 1'b1;
      end else if (func_d[`RIOC_F_RMT_RST]) begin
        trip_ind_q <= 1'b0;
      end
      relay_fail_out_q <= relay_defect | dc_supply_fault;
    end
  end

  // --------------------------------------------------------------
  // Configurable outputs
  // --------------------------------------------------------------
  assign sig = {func_q[`RIOC_F_TC_FAIL], ct_fail_alarm_q, ct_fail_signal_q, trip_ind_q,
                func_q[19:0], prot_sig};

  generate
    for (g = 0; g < NBO; g = g + 1) begin : g_bo
      rioc_out_relay #(
        .NSIG(32),
        .SW(SW),
        .HW(HW)
      ) u_bo (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .sig(sig),
        .sel(out_cfg_q[g*32 +: 4*SW]),
        .gate_en(out_cfg_q[g*32+20 +: 4]),
        .use_and(out_cfg_q[g*32+24]),
        .mode(out_cfg_q[g*32+26 +: 2]),
        .hold_ticks(out_hold_q[g*HW +: HW]),
        .latch_clr(func_d[`RIOC_F_RMT_RST]),
        .out_q(relay_w[g])
      );
    end
  endgenerate

  always @* begin
    output_relay = relay_w;
  end

  // --------------------------------------------------------------
  // CT failure supervision; latching keeps signal until remote reset
  // --------------------------------------------------------------
  assign ctf_detect = three_phase_q && ctf_en_q != `RIOC_CT_FAIL_ENABLE_SWITCH_OFF && !func_d[`RIOC_F_CTF_BLK] &&
                      ((residual_overcurrent_detect && !residual_overvoltage_detect) ||
                       func_d[`RIOC_F_CTF_EXT]);

  always @(posedge core_clk) begin
    if (rst) begin
      ct_fail_signal_q <= 1'b0;
      drop_cnt_q <= 4'h0;
      err_cnt_q <= 14'h0;
      ct_fail_err_q <= 1'b0;
      ct_fail_block_q <= 1'b0;
      ct_fail_alarm_q <= 1'b0;
    end else if (ce) begin
      if (ctf_detect) begin
        ct_fail_signal_q <= 1'b1;
        drop_cnt_q <= 4'h0;
      end else if (ctf_en_q == `RIOC_CT_FAIL_ENABLE_SWITCH_OFF || !three_phase_q) begin
        ct_fail_signal_q <= 1'b0;
        drop_cnt_q <= 4'h0;
      end else if (ctf_en_q == `RIOC_CT_FAIL_ENABLE_SWITCH_ON) begin
        if (func_d[`RIOC_F_RMT_RST]) begin
          ct_fail_signal_q <= 1'b0;
        end
      end else if (ct_fail_signal_q) begin
        if (drop_cnt_q >= `RIOC_CTF_DROP_TICKS) begin
          ct_fail_signal_q <= 1'b0;
          drop_cnt_q <= 4'h0;
        end else if (tick) begin
          drop_cnt_q <= drop_cnt_q + 4'h1;
        end
      end
      if (!ct_fail_signal_q) begin
        err_cnt_q <= 14'h0;
        ct_fail_err_q <= 1'b0;
      end else if (err_cnt_q >= CTF_ERR_TICKS) begin
        ct_fail_err_q <= 1'b1;
      end else if (tick) begin
        err_cnt_q <= err_cnt_q + 14'h1;
      end
      ct_fail_alarm_q <= ct_fail_signal_q;
      ct_fail_block_q <= ct_fail_signal_q;
    end
  end

  // --------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      polarity_q <= {NBI{1'b0}};
      group_sel_q <= {3*NBI{1'b0}};
      ctf_en_q <= `RIOC_CT_FAIL_ENABLE_SWITCH_OFF;
      three_phase_q <= 1'b1;
      alarm_map_q <= {4*NBI{1'b0}};
      func_map_q <= {`RIOC_NFUNC*NBI{1'b0}};
      bi_pu_q <= {BTW*NBI{1'b0}};
      bi_do_q <= {BTW*NBI{1'b0}};
      out_cfg_q <= {32*NBO{1'b0}};
      out_hold_q <= {HW*NBO{1'b0}};
    end else if (ce && reg_wr) begin
      if (reg_addr == `RIOC_REG_POLARITY) begin
        polarity_q <= reg_wdata[NBI-1:0];
      end
      if (reg_addr == `RIOC_REG_GROUPSEL) begin
        group_sel_q <= reg_wdata[3*NBI-1:0];
      end
      if (reg_addr == `RIOC_REG_CTF_CTRL) begin
        ctf_en_q <= reg_wdata[1:0];
        three_phase_q <= reg_wdata[4];
      end
      if (reg_addr == `RIOC_REG_ALARM_MAP) begin
        alarm_map_q <= reg_wdata[4*NBI-1:0];
      end
      for (k = 0; k < NBI; k = k + 1) begin
        if (reg_addr == `RIOC_REG_FUNC_BASE + 4 * k) begin
          func_map_q[k*`RIOC_NFUNC +: `RIOC_NFUNC] <= reg_wdata[`RIOC_NFUNC-1:0];
        end
        if (reg_addr == `RIOC_REG_BI_PU_BASE + 4 * k) begin
          bi_pu_q[k*BTW +: BTW] <= clip_bi(reg_wdata);
        end
        if (reg_addr == `RIOC_REG_BI_DO_BASE + 4 * k) begin
          bi_do_q[k*BTW +: BTW] <= clip_bi(reg_wdata);
        end
      end
      for (k = 0; k < NBO; k = k + 1) begin
        if (reg_addr == `RIOC_REG_OUT_BASE + 8 * k) begin
          out_cfg_q[k*32 +: 32] <= reg_wdata;
        end
        if (reg_addr == `RIOC_REG_OUT_BASE + 8 * k + 4) begin
          out_hold_q[k*HW +: HW] <= clip_hold(reg_wdata);
        end
      end
    end
  end

  // --------------------------------------------------------------
  // Register reads; unmapped addresses read zero
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata_q <= 32'h0;
    end else if (ce) begin
      reg_rdata_q <= 32'h0;
      if (reg_rd) begin
        if (reg_addr == `RIOC_REG_POLARITY) begin
          reg_rdata_q[NBI-1:0] <= polarity_q;
        end
        if (reg_addr == `RIOC_REG_GROUPSEL) begin
          reg_rdata_q[3*NBI-1:0] <= group_sel_q;
        end
        if (reg_addr == `RIOC_REG_CTF_CTRL) begin
          reg_rdata_q[4:0] <= {three_phase_q, 2'h0, ctf_en_q};
        end
        if (reg_addr == `RIOC_REG_STATUS) begin
          reg_rdata_q[25:0] <= {active_group_q, alarm_show_q, ct_fail_err_q,
                                ct_fail_signal_q, trip_ind_q, bi_prev_q[NBI-1:0],
                                relay_fail_out_q, output_relay};
        end
        if (reg_addr == `RIOC_REG_ALARM_MAP) begin
          reg_rdata_q[4*NBI-1:0] <= alarm_map_q;
        end
        for (k = 0; k < NBI; k = k + 1) begin
          if (reg_addr == `RIOC_REG_FUNC_BASE + 4 * k) begin
            reg_rdata_q[`RIOC_NFUNC-1:0] <= func_map_q[k*`RIOC_NFUNC +: `RIOC_NFUNC];
          end
          if (reg_addr == `RIOC_REG_BI_PU_BASE + 4 * k) begin
            reg_rdata_q[BTW-1:0] <= bi_pu_q[k*BTW +: BTW];
          end
          if (reg_addr == `RIOC_REG_BI_DO_BASE + 4 * k) begin
            reg_rdata_q[BTW-1:0] <= bi_do_q[k*BTW +: BTW];
          end
        end
        for (k = 0; k < NBO; k = k + 1) begin
          if (reg_addr == `RIOC_REG_OUT_BASE + 8 * k) begin
            reg_rdata_q <= out_cfg_q[k*32 +: 32];
          end
          if (reg_addr == `RIOC_REG_OUT_BASE + 8 * k + 4) begin
            reg_rdata_q[HW-1:0] <= out_hold_q[k*HW +: HW];
          end
        end
      end
    end
  end

endmodule

// ==== rioc_properties.sv ====
// Concurrent checks on the scheme logic top ports
`timescale 1ns/1ns
module rioc_props #(
  parameter TICK_CYC = 10,
  parameter CTF_ERR_TICKS = 5
) (
  input wire core_clk, // Clock
  input wire rst, // Sync reset
  input wire ce, // Clock enable
  input wire [7:0] reg_addr, // Address
  input wire reg_rd, // Read strobe
  input wire [31:0] reg_rdata_q, // Read data
  input wire relay_defect, // Defect
  input wire dc_supply_fault, // Supply fault
  input wire trip_cmd, // Trip command
  input wire [6:0] output_relay, // Relays
  input wire relay_fail_out_q, // Fail contact
  input wire trip_ind_q, // Trip indication
  input wire ct_fail_signal_q, // CT fail
  input wire ct_fail_err_q, // CT fail error
  input wire [19:0] func_q, // Functions
  input wire breaker_fail_init_q, // Breaker fail init
  input wire record_store_q, // Record pulse
  input wire clock_sync_q // Sync pulse
);
  // ------
  // Checks
  // ------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Cycles CT fail has been up
  reg [31:0] sig_cnt_q;
  always @(posedge core_clk) begin
    if (rst || !ct_fail_signal_q) begin
      sig_cnt_q <= 32'h0;
    end else begin
      sig_cnt_q <= sig_cnt_q + 32'h1;
    end
  end
  chk_fail_contact: assert property (
    ce && (relay_defect || dc_supply_fault) |=> relay_fail_out_q) else $error("fail contact open");
  chk_status_read: assert property (
    ce && reg_rd && reg_addr == 8'h0C |=> {reg_rdata_q[16], reg_rdata_q[7:0]} ==
    $past({trip_ind_q, relay_fail_out_q, output_relay})) else $error("status read wrong");
  chk_trip_set: assert property (ce && trip_cmd |=> trip_ind_q)
    else $error("trip indication not set");
  chk_trip_clear: assert property ($fell(trip_ind_q) |-> func_q[17] || $past(func_q[17]))
    else $error("trip indication dropped alone");
  chk_rec_pulse: assert property (record_store_q |=> !record_store_q)
    else $error("record pulse too long");
  chk_sync_follow: assert property ($rose(func_q[18]) |-> ##[0:2] clock_sync_q)
    else $error("no sync pulse");
  chk_bf_init: assert property (ce && |func_q[16:13] |-> ##[0:1] breaker_fail_init_q)
    else $error("breaker fail not initiated");
  chk_err_delay: assert property (
    $rose(ct_fail_err_q) |-> sig_cnt_q >= (CTF_ERR_TICKS - 1) * TICK_CYC) else $error("early error");
  cover property ($rose(ct_fail_err_q));
  cover property ($fell(trip_ind_q));
  cover property (record_store_q);
endmodule

// ==== rioc_field_model.sv ====
// Field contacts and breaker auxiliary wiring model
`timescale 1ns/1ns
module rioc_field_model (
  input wire [5:0] contact, // Plain field contacts
  input wire cb_closed, // Breaker closed
  output wire [7:0] bin_pin // To binary inputs
);
  // NO aux on pin 6, NC aux on pin 7
  assign bin_pin = {~cb_closed, cb_closed, contact};
endmodule

// ==== relay_io_mapping_and_ct_fail_supervision_tb_top.sv ====
// Self-checking bench for the scheme logic block
`timescale 1ns/1ns
module relay_io_mapping_and_ct_fail_supervision_tb_top;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg reg_wr = 1'b0, reg_rd = 1'b0, oc = 1'b0, ov = 1'b0, dfct = 1'b0, sup = 1'b0, trip = 1'b0;
  reg cb = 1'b0;
  reg [7:0] reg_addr = 8'h00, prot = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg [5:0] cont = 6'h00;
  wire [7:0] pins;
  wire [31:0] rdata;
  wire [6:0] relay;
  wire fail_q, trip_q, ctf_q, err_q, blk_q, bf_q, rec_q, sync_q;
  wire [2:0] grp;
  wire [3:0] alm;
  wire [19:0] func;
  integer n_errors = 0, comparisons = 0, i, n_rec, n_syn;
  // ------
  // Design and field side
  // ------
  rioc_field_model rioc_field_model_i (.contact(cont), .cb_closed(cb), .bin_pin(pins));
  rioc_top #(.TICK_CYC(10), .CTF_ERR_TICKS(5)) rioc_top_i (.core_clk, .rst, .ce(1'b1),
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q(rdata), .bin_pin(pins), .prot_sig(prot),
    .residual_overcurrent_detect(oc), .residual_overvoltage_detect(ov), .relay_defect(dfct),
    .dc_supply_fault(sup), .trip_cmd(trip), .output_relay(relay), .relay_fail_out_q(fail_q),
    .trip_ind_q(trip_q), .active_group_q(grp), .alarm_show_q(alm), .ct_fail_signal_q(ctf_q),
    .ct_fail_err_q(err_q), .ct_fail_block_q(blk_q), .ct_fail_alarm_q(), .func_q(func),
    .breaker_fail_init_q(bf_q), .record_store_q(rec_q), .clock_sync_q(sync_q));
  // Clock, 4 ns period
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task cyc(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task check(input [63:0] name, input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // One-cycle strobes
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
      cyc(1);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      cyc(1);
      check("rdata", rdata, exp);
    end
  endtask
  // Remote reset on input 1; counts pulses
  task pulse_reset;
    begin
      n_rec = 0;
      n_syn = 0;
      cont[1] <= 1'b1;
      for (i = 0; i < 12; i = i + 1) begin
        cyc(1);
        n_rec = n_rec + rec_q;
        n_syn = n_syn + sync_q;
      end
      cont[1] <= 1'b0;
      cyc(3);
    end
  endtask
  task t_regs;
    begin
      rdc(8'h08, 32'h10);
      rdc(8'h0C, 32'h8000);
      wr(8'hFC, 32'hFFFF_FFFF);
      rdc(8'hFC, 32'h0);
      dfct <= 1'b1;
      cyc(3);
      check("fail", fail_q, 1);
      dfct <= 1'b0;
      sup <= 1'b1;
      cyc(2);
      rdc(8'h0C, 32'h8080);
      sup <= 1'b0;
    end
  endtask
  task t_inputs;
    begin
      wr(8'h20, 32'h403F);
      wr(8'h38, 32'h800);
      wr(8'h3C, 32'h1000);
      wr(8'h40, 32'h3);
      wr(8'h04, 32'h2);
      wr(8'h10, 32'h1);
      cont[0] <= 1'b1;
      cb <= 1'b1;
      cyc(15);
      check("pickup", func[0], 0);
      check("cb", func[12:11], 1);
      cyc(30);
      check("recl", func[5:0], 32'h3F);
      check("bfinit", {func[14], bf_q}, 3);
      check("group", grp, 1);
      check("alarm", alm, 1);
      wr(8'h00, 32'h1);
      cyc(5);
      check("invert", func[0], 0);
      wr(8'h00, 32'h0);
      cont[0] <= 1'b0;
    end
  endtask
  task t_latch;
    begin
      wr(8'h80, 32'h0C10_0000);
      wr(8'h24, 32'hE_0000);
      prot[0] <= 1'b1;
      trip <= 1'b1;
      cyc(2);
      prot[0] <= 1'b0;
      trip <= 1'b0;
      cyc(5);
      check("latch", {relay[0], trip_q}, 3);
      pulse_reset;
      check("release", {relay[0], trip_q}, 0);
      check("pulses", {n_rec[3:0], n_syn[3:0]}, 32'h11);
    end
  endtask
  // Dwell or delayed drop-off, hold 5 ticks
  task t_hold(input [31:0] cfg, input [31:0] tail);
    begin
      wr(8'h88, cfg);
      wr(8'h8C, 32'h5);
      prot[1] <= 1'b1;
      cyc(2);
      prot[1] <= 1'b0;
      cyc(30);
      check("short", relay[1], 1);
      cyc(40);
      check("expired", relay[1], 0);
      prot[1] <= 1'b1;
      cyc(90);
      check("long", relay[1], 1);
      prot[1] <= 1'b0;
      cyc(4);
      check("tail", relay[1], tail);
      cyc(70);
    end
  endtask
  task t_gate;
    begin
      wr(8'h90, 32'h0130_0062);
      prot[2] <= 1'b1;
      cyc(3);
      check("and1", relay[2], 0);
      prot[3] <= 1'b1;
      cyc(3);
      check("and2", relay[2], 1);
      prot[3] <= 1'b0;
      cyc(3);
      check("inst", relay[2], 0);
    end
  endtask
  task t_ctf;
    begin
      wr(8'h08, 32'h12);
      oc <= 1'b1;
      cyc(10);
      check("ctf", {ctf_q, blk_q}, 3);
      cyc(60);
      check("err", err_q, 1);
      oc <= 1'b0;
      cyc(70);
      check("hold", ctf_q, 1);
      cyc(60);
      check("drop", ctf_q, 0);
      ov <= 1'b1;
      oc <= 1'b1;
      cyc(20);
      check("volt", ctf_q, 0);
      ov <= 1'b0;
      wr(8'h08, 32'h10);
      cyc(20);
      check("off", ctf_q, 0);
      wr(8'h08, 32'h02);
      cyc(20);
      check("2p", ctf_q, 0);
      wr(8'h08, 32'h11);
      cyc(10);
      oc <= 1'b0;
      cyc(150);
      check("latched", ctf_q, 1);
      pulse_reset;
      check("cleared", ctf_q, 0);
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #40000;
    n_errors = n_errors + 1;
    give_verdict;
  end
  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(4);
    t_regs;
    t_inputs;
    t_latch;
    t_hold(32'h0810_0001, 0);
    t_hold(32'h0410_0001, 1);
    t_gate;
    t_ctf;
    give_verdict;
  end
endmodule
bind rioc_top rioc_props #(.TICK_CYC(TICK_CYC), .CTF_ERR_TICKS(CTF_ERR_TICKS)) rioc_props_i (
  .core_clk, .rst, .ce, .reg_addr, .reg_rd, .reg_rdata_q, .relay_defect, .dc_supply_fault,
  .trip_cmd, .output_relay, .relay_fail_out_q, .trip_ind_q, .ct_fail_signal_q, .ct_fail_err_q,
  .func_q, .breaker_fail_init_q, .record_store_q, .clock_sync_q);
